/* hdl/lane_serdes_pkg.sv */
// Constants shared by the high-speed lane serializer and deserializer.
package lane_serdes_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Control register fields.
  localparam int          CTRL_TX_MODE   = 0;
  localparam int          CTRL_REVERSE   = 1;
  localparam int          CTRL_FIFO_EN   = 2;
  localparam int          CTRL_CLK_ROLE  = 3;
  localparam int          CTRL_LANE_LSB  = 4;
  localparam int          CTRL_GROUP_LSB = 8;
  localparam int          CTRL_SRC_LSB   = 12;
  localparam int          CTRL_DINIT_LSB = 16;

  // Status register fields.
  localparam int          STAT_EMPTY     = 0;
  localparam int          STAT_LEVEL_LSB = 1;
  localparam int          STAT_DLY_LSB   = 8;
  localparam int          STAT_LINKED    = 12;
  localparam int          STAT_OVERFLOW  = 13;

  // ----------------------------------------------------------------
  // Lane geometry
  // ----------------------------------------------------------------
  localparam int          WORD_W         = 8;
  localparam int          BITS_PER_TICK  = 2;
  localparam int          HIST_W         = 16;
  localparam int          LANE_W         = 3;
  localparam int          GROUP_W        = 4;
  localparam logic [3:0]  GROUP_COUNT    = 4'hC;
  localparam int          DLY_W          = 3;
  localparam logic [2:0]  DLY_MAX        = 3'h7;
  localparam logic [2:0]  DLY_MIN        = 3'h0;
  localparam logic [1:0]  DIV_LAST       = 2'h3;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          PTR_W          = 3;
  localparam int          LEVEL_W        = 4;
  localparam logic [3:0]  LEVEL_FULL     = 4'h8;
  localparam logic [3:0]  LEVEL_EMPTY    = 4'h0;

endpackage : lane_serdes_pkg

/* hdl/lane_serdes.sv */
// One configurable high-speed lane: clock lane or data lane, receive or transmit.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps

module lane_serdes (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic [1:0]  padHsIn,
  input  wire logic        padPosIn,
  input  wire logic        padNegIn,
  output logic      [1:0]  padHsOut,
  output logic             padHsOe,
  output logic             padPosOut,
  output logic             padPosOe,
  output logic             padNegOut,
  output logic             padNegOe,
  output logic             padRxBufferEnable,
  output logic             padTermEnable,
  input  wire logic        serialClock,
  input  wire logic        parallelClock,
  output logic             forwardedSerialClock,
  output logic             forwardedParallelClock,
  output logic             globalNetworkLaneClock,
  output logic      [7:0]  rxParallelWord,
  output logic             rxWordValid,
  output logic             rxQueueEmpty,
  input  wire logic        rxQueueReadEnable,
  input  wire logic        rxLaneReset,
  input  wire logic [7:0]  txParallelWord,
  input  wire logic        txReset,
  input  wire logic        highspeedDriveEnable,
  input  wire logic        highspeedReceiverEnable,
  input  wire logic        highspeedTerminationEnable,
  input  wire logic        lowpowerPosDriveValue,
  input  wire logic        lowpowerNegDriveValue,
  input  wire logic        lowpowerPosDriveEnable,
  input  wire logic        lowpowerNegDriveEnable,
  output logic             lowpowerPosPadLevel,
  output logic             lowpowerNegPadLevel,
  input  wire logic        delayAdjustEnable,
  input  wire logic        delayAdjustDirection,
  input  wire logic        delayCounterReset
);

  typedef struct packed {
    logic                                                     txMode;
    logic                                                     reversible;
    logic                                                     fifoEnable;
    logic                                                     clockRole;
    logic [lane_serdes_pkg::LANE_W-1:0]                       laneIndex;
    logic [lane_serdes_pkg::GROUP_W-1:0]                      laneGroup;
    logic [lane_serdes_pkg::GROUP_W-1:0]                      sourceGroup;
    logic [lane_serdes_pkg::DLY_W-1:0]                        delayInit;
    logic [1:0]                                               divPhase;
    logic [1:0]                                               hsSync1;
    logic [1:0]                                               hsSync2;
    logic [1:0]                                               lpSync1;
    logic [1:0]                                               lpSync2;
    logic [lane_serdes_pkg::HIST_W-1:0]                       history;
    logic [lane_serdes_pkg::DLY_W-1:0]                        delayCount;
    logic [lane_serdes_pkg::FIFO_DEPTH-1:0]
          [lane_serdes_pkg::WORD_W-1:0]                       mem;
    logic [lane_serdes_pkg::PTR_W-1:0]                        wrPtr;
    logic [lane_serdes_pkg::PTR_W-1:0]                        rdPtr;
    logic [lane_serdes_pkg::LEVEL_W-1:0]                      level;
    logic                                                     overflow;
    logic [lane_serdes_pkg::WORD_W-1:0]                       rxWord;
    logic                                                     rxValid;
    logic [lane_serdes_pkg::WORD_W-1:0]                       txShift;
    logic [1:0]                                               txBits;
    logic                                                     txOe;
    logic                                                     posOut;
    logic                                                     posOe;
    logic                                                     negOut;
    logic                                                     negOe;
    logic                                                     posLevel;
    logic                                                     negLevel;
    logic                                                     bufEnable;
    logic                                                     termEnable;
    logic                                                     fwdSerial;
    logic                                                     fwdParallel;
    logic                                                     globalClk;
    logic [31:0]                                              rdata;
  } state_s;

  state_s state_q;
  state_s state_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // A group index is usable only below the group count.
  function automatic logic groupValid(input logic [lane_serdes_pkg::GROUP_W-1:0] g);
    groupValid = (g < lane_serdes_pkg::GROUP_COUNT);
  endfunction : groupValid

  // Saturating step of the input delay counter.
  function automatic logic [lane_serdes_pkg::DLY_W-1:0] delayStep(
    input logic [lane_serdes_pkg::DLY_W-1:0] cur,
    input logic                              up
  );
    if (up) begin
      delayStep = (cur == lane_serdes_pkg::DLY_MAX) ? cur : cur + 3'h1;
    end else begin
      delayStep = (cur == lane_serdes_pkg::DLY_MIN) ? cur : cur - 3'h1;
    end
  endfunction : delayStep

  logic                              linked;
  logic                              rxActive;
  logic                              fastTick;
  logic                              slowTick;
  logic [lane_serdes_pkg::HIST_W-1:0] histNext;
  logic [lane_serdes_pkg::WORD_W-1:0] capWord;
  logic                              push;
  logic                              pop;

  always_comb begin
    state_d = state_q;

    // ----------------------------------------------------------------
    // Clock sourcing
    // ----------------------------------------------------------------
    if (state_q.clockRole) begin
      linked = groupValid(state_q.laneGroup);
    end else begin
      linked = groupValid(state_q.laneGroup) &&
               (state_q.laneGroup == state_q.sourceGroup);
    end
    rxActive = !state_q.txMode && highspeedReceiverEnable && linked;

    if (state_q.txMode) begin
      fastTick = serialClock;
      slowTick = parallelClock;
    end else if (state_q.clockRole) begin
      fastTick = rxActive;
      slowTick = rxActive && (state_q.divPhase == lane_serdes_pkg::DIV_LAST);
    end else begin
      fastTick = rxActive && serialClock;
      slowTick = rxActive && parallelClock;
    end

    if (rxActive && state_q.clockRole) begin
      state_d.divPhase = state_q.divPhase + 2'h1;
    end

    // Forwarded clocks exist only on a receiving clock lane.
    state_d.fwdSerial   = rxActive && state_q.clockRole && fastTick;
    state_d.fwdParallel = rxActive && state_q.clockRole && slowTick;
    state_d.globalClk   = rxActive && state_q.clockRole && slowTick;

    // ----------------------------------------------------------------
    // Pad synchronisers
    // ----------------------------------------------------------------
    state_d.hsSync1 = padHsIn;
    state_d.hsSync2 = state_q.hsSync1;
    state_d.lpSync1 = {padNegIn, padPosIn};
    state_d.lpSync2 = state_q.lpSync1;

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // The earlier bit of each pair lands at the lower index.
    histNext = {state_q.hsSync2[1], state_q.hsSync2[0],
                state_q.history[lane_serdes_pkg::HIST_W-1:lane_serdes_pkg::BITS_PER_TICK]};
    capWord  = histNext[(lane_serdes_pkg::HIST_W - lane_serdes_pkg::WORD_W
                         - int'(state_q.delayCount)) +: lane_serdes_pkg::WORD_W];
    if (fastTick && !state_q.txMode) begin
      state_d.history = histNext;
    end

    if (slowTick && !state_q.txMode) begin
      if (delayCounterReset) begin
        state_d.delayCount = state_q.delayInit;
      end else if (delayAdjustEnable) begin
        state_d.delayCount = delayStep(state_q.delayCount, delayAdjustDirection);
      end
    end

    push = slowTick && !state_q.txMode && !state_q.clockRole && state_q.fifoEnable;
    pop  = state_q.fifoEnable && rxQueueReadEnable &&
           (state_q.level != lane_serdes_pkg::LEVEL_EMPTY);
    state_d.rxValid = 1'b0;

    if (pop) begin
      state_d.rxWord  = state_q.mem[state_q.rdPtr];
      state_d.rxValid = 1'b1;
      state_d.rdPtr   = state_q.rdPtr + 3'h1;
    end
    if (push) begin
      if (pop || (state_q.level != lane_serdes_pkg::LEVEL_FULL)) begin
        state_d.mem[state_q.wrPtr] = capWord;
        state_d.wrPtr              = state_q.wrPtr + 3'h1;
      end else begin
        state_d.overflow = 1'b1;
      end
    end
    if (push && !pop && (state_q.level != lane_serdes_pkg::LEVEL_FULL)) begin
      state_d.level = state_q.level + 4'h1;
    end else if (pop && !push) begin
      state_d.level = state_q.level - 4'h1;
    end

    if (slowTick && !state_q.txMode && !state_q.clockRole && !state_q.fifoEnable) begin
      state_d.rxWord  = capWord;
      state_d.rxValid = 1'b1;
    end

    if (rxLaneReset) begin
      state_d.history = '0;
      state_d.wrPtr   = '0;
      state_d.rdPtr   = '0;
      state_d.level   = lane_serdes_pkg::LEVEL_EMPTY;
      state_d.rxValid = 1'b0;
    end

    // ----------------------------------------------------------------
    // Transmit path
    // ----------------------------------------------------------------
    if (state_q.txMode && fastTick) begin
      if (slowTick) begin
        state_d.txBits  = txParallelWord[1:0];
        state_d.txShift = {2'h0, txParallelWord[7:2]};
      end else begin
        state_d.txBits  = state_q.txShift[1:0];
        state_d.txShift = {2'h0, state_q.txShift[7:2]};
      end
    end
    if (txReset || !state_q.txMode) begin
      state_d.txBits  = '0;
      state_d.txShift = '0;
    end
    state_d.txOe = state_q.txMode && highspeedDriveEnable;

    // ----------------------------------------------------------------
    // Low-power pads and buffer controls
    // ----------------------------------------------------------------
    state_d.posOut = lowpowerPosDriveValue;
    state_d.negOut = lowpowerNegDriveValue;
    if (state_q.txMode) begin
      state_d.posOe    = lowpowerPosDriveEnable;
      state_d.negOe    = lowpowerNegDriveEnable;
      state_d.posLevel = state_q.reversible && state_q.lpSync2[0];
      state_d.negLevel = state_q.reversible && state_q.lpSync2[1];
    end else begin
      state_d.posOe    = state_q.reversible && lowpowerPosDriveEnable;
      state_d.negOe    = state_q.reversible && lowpowerNegDriveEnable;
      state_d.posLevel = state_q.lpSync2[0];
      state_d.negLevel = state_q.lpSync2[1];
    end
    state_d.bufEnable  = !state_q.txMode && highspeedReceiverEnable;
    state_d.termEnable = !state_q.txMode && highspeedTerminationEnable;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    state_d.rdata = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        lane_serdes_pkg::REG_CTRL: begin
          state_d.rdata[lane_serdes_pkg::CTRL_TX_MODE] = state_q.txMode;
          state_d.rdata[lane_serdes_pkg::CTRL_REVERSE] = state_q.reversible;
          state_d.rdata[lane_serdes_pkg::CTRL_FIFO_EN] = state_q.fifoEnable;
          state_d.rdata[lane_serdes_pkg::CTRL_CLK_ROLE] = state_q.clockRole;
          state_d.rdata[lane_serdes_pkg::CTRL_LANE_LSB +: lane_serdes_pkg::LANE_W] =
            state_q.laneIndex;
          state_d.rdata[lane_serdes_pkg::CTRL_GROUP_LSB +: lane_serdes_pkg::GROUP_W] =
            state_q.laneGroup;
          state_d.rdata[lane_serdes_pkg::CTRL_SRC_LSB +: lane_serdes_pkg::GROUP_W] =
            state_q.sourceGroup;
          state_d.rdata[lane_serdes_pkg::CTRL_DINIT_LSB +: lane_serdes_pkg::DLY_W] =
            state_q.delayInit;
        end
        lane_serdes_pkg::REG_STATUS: begin
          state_d.rdata[lane_serdes_pkg::STAT_EMPTY] =
            (state_q.level == lane_serdes_pkg::LEVEL_EMPTY);
          state_d.rdata[lane_serdes_pkg::STAT_LEVEL_LSB +: lane_serdes_pkg::LEVEL_W] =
            state_q.level;
          state_d.rdata[lane_serdes_pkg::STAT_DLY_LSB +: lane_serdes_pkg::DLY_W] =
            state_q.delayCount;
          state_d.rdata[lane_serdes_pkg::STAT_LINKED]   = linked;
          state_d.rdata[lane_serdes_pkg::STAT_OVERFLOW] = state_q.overflow;
        end
        default: begin
          state_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (regWrite) begin
      case (regAddr)
        lane_serdes_pkg::REG_CTRL: begin
          state_d.txMode      = regWdata[lane_serdes_pkg::CTRL_TX_MODE];
          state_d.reversible  = regWdata[lane_serdes_pkg::CTRL_REVERSE];
          state_d.fifoEnable  = regWdata[lane_serdes_pkg::CTRL_FIFO_EN];
          state_d.clockRole   = regWdata[lane_serdes_pkg::CTRL_CLK_ROLE];
          state_d.laneIndex   =
            regWdata[lane_serdes_pkg::CTRL_LANE_LSB +: lane_serdes_pkg::LANE_W];
          state_d.laneGroup   =
            regWdata[lane_serdes_pkg::CTRL_GROUP_LSB +: lane_serdes_pkg::GROUP_W];
          state_d.sourceGroup =
            regWdata[lane_serdes_pkg::CTRL_SRC_LSB +: lane_serdes_pkg::GROUP_W];
          state_d.delayInit   =
            regWdata[lane_serdes_pkg::CTRL_DINIT_LSB +: lane_serdes_pkg::DLY_W];
        end
        lane_serdes_pkg::REG_STATUS: begin
          // Write one clears overflow; a new overflow in the same cycle wins.
          if (regWdata[lane_serdes_pkg::STAT_OVERFLOW] && !(push && !pop &&
              (state_q.level == lane_serdes_pkg::LEVEL_FULL))) begin
            state_d.overflow = 1'b0;
          end
        end
        default: begin
          state_d.overflow = state_d.overflow;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdata               = state_q.rdata;
  assign padHsOut               = state_q.txOe ? state_q.txBits : 2'h0;
  assign padHsOe                = state_q.txOe;
  assign padPosOut              = state_q.posOut;
  assign padPosOe               = state_q.posOe;
  assign padNegOut              = state_q.negOut;
  assign padNegOe               = state_q.negOe;
  assign padRxBufferEnable      = state_q.bufEnable;
  assign padTermEnable          = state_q.termEnable;
  assign forwardedSerialClock   = state_q.fwdSerial;
  assign forwardedParallelClock = state_q.fwdParallel;
  assign globalNetworkLaneClock = state_q.globalClk;
  assign rxParallelWord         = state_q.rxWord;
  assign rxWordValid            = state_q.rxValid;
  assign rxQueueEmpty           = (state_q.level == lane_serdes_pkg::LEVEL_EMPTY);
  assign lowpowerPosPadLevel    = state_q.posLevel;
  assign lowpowerNegPadLevel    = state_q.negLevel;

endmodule : lane_serdes

/* verif/dphy_peer.sv */
// Remote lane transmitter model that drives the receive pads.
`timescale 1ns/100ps
module dphy_peer (
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic [7:0] word,
  output logic      [1:0] hsBits,
  output logic            lpLevel
);
  logic [1:0] phase = 2'h0;
  initial hsBits = 2'h0;
  // Low-power lines rest high between bursts.
  assign lpLevel = !send;
  always @(posedge clk) begin
    phase <= send ? phase + 2'h1 : 2'h0;
    // Outside a burst the line toggles so a stale value never matches by luck.
    hsBits <= send ? word[2*phase +: 2] : ~hsBits;
  end
endmodule : dphy_peer

/* verif/lane_serdes_assertions.sv */
// Port assertions for the high-speed lane.
`timescale 1ns/100ps
module lane_serdes_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [1:0] padHsOut,
  input wire logic       padHsOe,
  input wire logic       highspeedDriveEnable,
  input wire logic       highspeedReceiverEnable,
  input wire logic       padRxBufferEnable,
  input wire logic       highspeedTerminationEnable,
  input wire logic       padTermEnable,
  input wire logic       globalNetworkLaneClock,
  input wire logic       forwardedParallelClock,
  input wire logic       forwardedSerialClock,
  input wire logic       padPosOe,
  input wire logic       lowpowerPosDriveEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_hs_quiet: assert property (!padHsOe |-> padHsOut == 2'h0)
    else $error("high-speed bits driven while disabled");
  chk_oe_off: assert property (!highspeedDriveEnable |=> !padHsOe)
    else $error("high-speed enable without request");
  chk_rxbuf_off: assert property (!highspeedReceiverEnable |=> !padRxBufferEnable)
    else $error("receive buffer on without request");
  chk_term_off: assert property (!highspeedTerminationEnable |=> !padTermEnable)
    else $error("termination on without request");
  chk_global_clock: assert property (
    globalNetworkLaneClock == forwardedParallelClock)
    else $error("global clock differs from slow clock");
  chk_slow_fast: assert property (forwardedParallelClock |-> forwardedSerialClock)
    else $error("slow tick without fast tick");
  chk_quarter_rate: assert property (
    $rose(forwardedParallelClock) |=> !forwardedParallelClock [*3])
    else $error("slow clock faster than a quarter");
  chk_lp_enable: assert property (padPosOe |-> $past(lowpowerPosDriveEnable))
    else $error("low-power drive without enable");
endmodule : lane_serdes_checker

bind lane_serdes lane_serdes_checker u_checker (.clk, .resetn, .padHsOut, .padHsOe,
  .highspeedDriveEnable, .highspeedReceiverEnable, .padRxBufferEnable, .padTermEnable,
  .highspeedTerminationEnable, .globalNetworkLaneClock, .forwardedParallelClock,
  .forwardedSerialClock, .padPosOe, .lowpowerPosDriveEnable);

/* verif/mipi_lane_serdes_bench.sv */
// Self-checking bench for the high-speed lane.
`timescale 1ns/100ps
`define CHECK(what, exp, got) begin nChecks++; if ((got) !== (exp)) begin failCount++; \
  $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module mipi_lane_serdes_bench;
  logic clk, resetn, regWrite, regRead, padPosIn, padNegIn, serialClock, parallelClock, send;
  logic rxQueueReadEnable, rxLaneReset, txReset, highspeedDriveEnable, highspeedReceiverEnable;
  logic highspeedTerminationEnable, lowpowerPosDriveValue, lowpowerNegDriveValue;
  logic lowpowerPosDriveEnable, lowpowerNegDriveEnable, delayAdjustEnable, delayAdjustDirection;
  logic delayCounterReset, padHsOe, padPosOut, padPosOe, padNegOut, padNegOe, padRxBufferEnable;
  logic padTermEnable, forwardedSerialClock, forwardedParallelClock, globalNetworkLaneClock;
  logic rxWordValid, rxQueueEmpty, lowpowerPosPadLevel, lowpowerNegPadLevel;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0] padHsIn, padHsOut;
  logic [7:0] rxParallelWord, txParallelWord, word;
  int failCount = 0, nChecks = 0, cnt;
  localparam logic [7:0] TX = 8'hB4;
  lane_serdes DUT (.*);
  dphy_peer peer (.clk(clk), .send(send), .word(word), .hsBits(padHsIn), .lpLevel(padPosIn));
  assign padNegIn = padPosIn;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    `CHECK("regRdata", e, regRdata)
  endtask : rd
  task automatic tick(input logic [2:0] dl);
    @(posedge clk);
    {parallelClock, delayCounterReset, delayAdjustEnable, delayAdjustDirection} <= {1'b1, dl};
    @(posedge clk);
    {parallelClock, delayCounterReset, delayAdjustEnable, delayAdjustDirection} <= 4'h0;
  endtask : tick
  task automatic rxw(input logic [7:0] w, input logic q);
    @(posedge clk);
    {send, word} <= {1'b1, w};
    repeat (4) @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    tick(3'h0);
    if (q) begin
      @(posedge clk);
      rxQueueReadEnable <= 1'b1;
      @(negedge clk);
      `CHECK("rxQueueEmpty", 1'b0, rxQueueEmpty)
      @(posedge clk);
      rxQueueReadEnable <= 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (rxWordValid === 1'b1) break;
    end
    `CHECK("rxParallelWord", w, rxParallelWord)
    if (q) `CHECK("rxQueueEmpty", 1'b1, rxQueueEmpty)
    if (rxWordValid !== 1'b1) begin
      failCount++;
      conclude();
    end
    $display("receive test done");
  endtask : rxw
  initial begin
    {regAddr, regWdata, regWrite, regRead, parallelClock, rxQueueReadEnable, rxLaneReset,
     txParallelWord, txReset, highspeedDriveEnable, lowpowerPosDriveValue, lowpowerNegDriveValue,
     lowpowerPosDriveEnable, lowpowerNegDriveEnable, delayAdjustEnable, delayAdjustDirection,
     delayCounterReset, send, word, resetn} = '0;
    {serialClock, highspeedReceiverEnable, highspeedTerminationEnable} = 3'h7;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(lane_serdes_pkg::REG_CTRL, lane_serdes_pkg::CTRL_RESET);
    wr(lane_serdes_pkg::REG_CTRL, 32'h0000_CC00);
    wr(4'h8, 32'hFFFF_FFFF);
    rd(lane_serdes_pkg::REG_CTRL, 32'h0000_CC00);
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_0001);
    wr(lane_serdes_pkg::REG_CTRL, 32'h0000_BB00);
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_1001);
    `CHECK("rx pads", 5'h1E, {padRxBufferEnable, padTermEnable, lowpowerPosPadLevel,
      lowpowerNegPadLevel, padPosOe})
    $display("register test done");
    wr(lane_serdes_pkg::REG_CTRL, 32'h0);
    rxw(8'h5A, 1'b0);
    wr(lane_serdes_pkg::REG_CTRL, 32'h4);
    rxw(8'hC3, 1'b1);
    tick(3'h0);
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_1002);
    @(posedge clk);
    rxLaneReset <= 1'b1;
    @(posedge clk);
    rxLaneReset <= 1'b0;
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_1001);
    wr(lane_serdes_pkg::REG_CTRL, 32'h0005_0000);
    repeat (9) tick(3'h3);
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_1701);
    tick(3'h2);
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_1601);
    tick(3'h4);
    rd(lane_serdes_pkg::REG_STATUS, 32'h0000_1501);
    $display("delay test done");
    wr(lane_serdes_pkg::REG_CTRL, 32'h8);
    repeat (8) @(posedge clk);
    cnt = 0;
    repeat (16) begin
      @(negedge clk);
      cnt += forwardedParallelClock;
    end
    `CHECK("slow pulses", 4, cnt)
    $display("clock lane test done");
    wr(lane_serdes_pkg::REG_CTRL, 32'h1);
    {highspeedDriveEnable, lowpowerPosDriveValue, lowpowerPosDriveEnable, txParallelWord} <=
      {3'h7, TX};
    repeat (4) @(posedge clk);
    tick(3'h0);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      `CHECK("padHsOut", TX[2*i +: 2], padHsOut)
    end
    `CHECK("tx pads", 6'h38, {padHsOe, padPosOe, padPosOut, padTermEnable, padRxBufferEnable,
      lowpowerPosPadLevel})
    tick(3'h0);
    txReset <= 1'b1;
    @(posedge clk);
    txReset <= 1'b0;
    @(negedge clk);
    `CHECK("padHsOut after reset", 2'h0, padHsOut)
    $display("transmit test done");
    conclude();
  end
endmodule : mipi_lane_serdes_bench
